// ===== hdl/rtp_pkg.sv
// Package: register map, field positions, reset values and bus carriers for the trim block
// ****************************************************************
// What this block does
// R1 - Trim code 01111111 inserts 127 extra timebase pulses every 15 seconds.
// R2 - Trim is two's complement; each step adds or removes one pulse per 15 s.
// R3 - Configuration registers return to reset values only on power-on reset.
// R4 - Writes to the clock run enable are ignored unless value write unlock is 1.
// R5 - Time value register writes pass only while value write unlock is set.
// R6 - Half second flag is read only; cleared by writing minutes/seconds low byte.
// R7 - Half second flag reads 0 in first half of each second, 1 in second.
// R8 - Power control enable bit activates power control when 1, deactivates when 0.
// R9 - Stability window clock is timebase divided by 2 when set, undivided when clear.
// R10 - Sample window clock is timebase divided by 2 when set, undivided when clear.
// R11 - Timebase source codes 11 and 10 select the mains input at 60 and 50 Hz.
// R12 - Timebase source code 01 selects low power oscillator, 00 the secondary crystal.
// R13 - Software writes minutes/seconds low byte after changing source to reset prescalers.
// R14 - Output select 11 power control, 10 timebase, 01 seconds, 00 alarm pulse.
// ****************************************************************
package rtp_pkg;
	localparam logic [3:0] OFS_CAL_CFG = 4'h0;
	localparam logic [3:0] OFS_PWR_CTL = 4'h4;
	localparam logic [3:0] OFS_VAL_LOW = 4'h8;
	localparam logic [3:0] OFS_VAL_HIGH = 4'hC;
	localparam int BIT_RUN_EN = 15;
	localparam int BIT_UNLOCK = 13;
	localparam int BIT_SYNC = 12;
	localparam int BIT_HALF = 11;
	localparam int BIT_OE = 10;
	localparam int POS_PTR = 8;
	localparam int POS_CAL = 0;
	localparam int BIT_PWC_EN = 15;
	localparam int BIT_PWC_POL = 14;
	localparam int BIT_STAB_PRE = 13;
	localparam int BIT_SAMP_PRE = 12;
	localparam int POS_SRC = 10;
	localparam int POS_OUTSEL = 8;
	localparam logic [7:0] CAL_RST = 8'h00;
	localparam logic [1:0] PTR_RST = 2'h0;
	localparam logic [1:0] SRC_RST = 2'h0;
	localparam logic [1:0] OUTSEL_RST = 2'h0;
	localparam logic [1:0] SRC_MAINS60 = 2'h3;
	localparam logic [1:0] SRC_MAINS50 = 2'h2;
	localparam logic [1:0] SRC_INTERNAL_LOW_POWER_OSC = 2'h1;
	localparam logic [1:0] SRC_SECONDARY_CRYSTAL_OSC = 2'h0;
	localparam logic [1:0] OUT_PWC = 2'h3;
	localparam logic [1:0] OUT_TIMEBASE = 2'h2;
	localparam logic [1:0] OUT_SECONDS = 2'h1;
	localparam logic [1:0] OUT_ALARM = 2'h0;
	localparam logic [3:0] TRIM_INTERVAL_S = 4'hF;
	localparam int SYNC_STAGES = 3;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} rtp_wb_req_s;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} rtp_wb_rsp_s;

	typedef struct packed {
		logic stb;
		logic high;
		logic [1:0] ptr;
		logic [1:0] be;
		logic [15:0] dat;
	} rtp_val_wr_s;
endpackage

// ===== hdl/rtp_trim_power.sv
// Module: calibration/configuration and power control registers with timebase and trim
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module rtp_trim_power #(
	parameter int SECONDARY_CRYSTAL_OSC_HZ = 32768,
	parameter int INTERNAL_LOW_POWER_OSC_HZ = 31250
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire rtp_pkg::rtp_wb_req_s wb_req,
	output rtp_pkg::rtp_wb_rsp_s wb_rsp,
	input wire logic secondary_crystal_osc_pin,
	input wire logic internal_low_power_osc_pin,
	input wire logic mains_pin,
	input wire logic ripple_pending,
	input wire logic [15:0] value_rd_data,
	input wire logic pwc_signal,
	input wire logic alarm_pulse,
	output rtp_pkg::rtp_val_wr_s val_wr,
	output logic [1:0] value_ptr,
	output logic clock_run_enable,
	output logic power_ctl_enable,
	output logic power_ctl_polarity,
	output logic prescaler_reset,
	output logic timebase_tick,
	output logic seconds_tick,
	output logic stab_window_tick,
	output logic samp_window_tick,
	output logic clk_out,
	output logic clk_out_en
);
	import rtp_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic run_en;
		logic unlock;
		logic oe;
		logic [1:0] ptr;
		logic [7:0] cal;
		logic pwc_en;
		logic pwc_pol;
		logic stab_pre;
		logic samp_pre;
		logic [1:0] src;
		logic [1:0] outsel;
		logic [2:0][SYNC_STAGES-1:0] sync;
		logic [2:0] level;
		logic [15:0] cnt;
		logic half;
		logic signed [8:0] adj;
		logic [3:0] sec15;
		logic stab_tgl;
		logic samp_tgl;
		logic tick;
		logic sec;
		logic stab_tick;
		logic samp_tick;
		logic presc_rst;
		logic cko;
		rtp_val_wr_s vw;
	} rtp_state_s;

	rtp_state_s s_q;
	rtp_state_s s_d;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [15:0] ticks_per_sec(input logic [1:0] src);
		case (src)
			SRC_MAINS60: ticks_per_sec = 16'd60;
			SRC_MAINS50: ticks_per_sec = 16'd50;
			SRC_INTERNAL_LOW_POWER_OSC: ticks_per_sec = INTERNAL_LOW_POWER_OSC_HZ[15:0];
			default: ticks_per_sec = SECONDARY_CRYSTAL_OSC_HZ[15:0];
		endcase
	endfunction

	function automatic logic [31:0] cfg_word(input rtp_state_s s, input logic ripple);
		cfg_word = 32'h0000_0000;
		cfg_word[BIT_RUN_EN] = s.run_en;
		cfg_word[BIT_UNLOCK] = s.unlock;
		cfg_word[BIT_SYNC] = ripple;
		cfg_word[BIT_HALF] = s.half;
		cfg_word[BIT_OE] = s.oe;
		cfg_word[POS_PTR +: 2] = s.ptr;
		cfg_word[POS_CAL +: 8] = s.cal;
	endfunction

	function automatic logic [31:0] pwc_word(input rtp_state_s s);
		pwc_word = 32'h0000_0000;
		pwc_word[BIT_PWC_EN] = s.pwc_en;
		pwc_word[BIT_PWC_POL] = s.pwc_pol;
		pwc_word[BIT_STAB_PRE] = s.stab_pre;
		pwc_word[BIT_SAMP_PRE] = s.samp_pre;
		pwc_word[POS_SRC +: 2] = s.src;
		pwc_word[POS_OUTSEL +: 2] = s.outsel;
	endfunction

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		logic take;
		logic wr;
		logic [2:0] pins;
		logic [2:0] rise;
		logic [1:0] lane;
		logic [15:0] tps;
		logic [16:0] nxt;
		logic [1:0] inc;
		logic minutes_seconds_value_low;
		take = 1'b0;
		wr = 1'b0;
		pins = {mains_pin, internal_low_power_osc_pin, secondary_crystal_osc_pin};
		rise = 3'h0;
		lane = 2'h0;
		tps = 16'h0000;
		nxt = 17'h00000;
		inc = 2'h0;
		minutes_seconds_value_low = 1'b0;
		s_d = s_q;
		s_d.vw.stb = 1'b0;
		s_d.presc_rst = 1'b0;
		s_d.tick = 1'b0;
		s_d.sec = 1'b0;
		s_d.stab_tick = 1'b0;
		s_d.samp_tick = 1'b0;

		// Pin synchronisers: a change counts once stages two and three agree
		for (int i = 0; i < 3; i++)
		begin
			s_d.sync[i] = {s_q.sync[i][1:0], pins[i]};
			if (s_q.sync[i][1] == s_q.sync[i][2])
			begin
				s_d.level[i] = s_q.sync[i][2];
				rise[i] = s_q.sync[i][2] & ~s_q.level[i];
			end
		end

		// Bus slave: one cycle to ack, ack dropped the cycle after
		take = wb_req.cyc & wb_req.stb & ~s_q.ack;
		wr = take & wb_req.we;
		s_d.ack = take;
		if (take & ~wb_req.we)
		begin
			case (wb_req.adr)
				OFS_CAL_CFG: s_d.rdat = cfg_word(s_q, ripple_pending);
				OFS_PWR_CTL: s_d.rdat = pwc_word(s_q);
				OFS_VAL_LOW, OFS_VAL_HIGH: s_d.rdat = {16'h0000, value_rd_data};
				default: s_d.rdat = 32'h0000_0000;
			endcase
		end

		if (wr && wb_req.adr == OFS_CAL_CFG)
		begin
			if (wb_req.sel[0])
				s_d.cal = wb_req.dat[POS_CAL +: 8];
			if (wb_req.sel[1])
			begin
				s_d.unlock = wb_req.dat[BIT_UNLOCK];
				s_d.oe = wb_req.dat[BIT_OE];
				s_d.ptr = wb_req.dat[POS_PTR +: 2];
				if (s_q.unlock)
					s_d.run_en = wb_req.dat[BIT_RUN_EN]; // R4
			end
		end

		if (wr && wb_req.adr == OFS_PWR_CTL && wb_req.sel[1])
		begin
			s_d.pwc_en = wb_req.dat[BIT_PWC_EN]; // R8
			s_d.pwc_pol = wb_req.dat[BIT_PWC_POL];
			s_d.stab_pre = wb_req.dat[BIT_STAB_PRE];
			s_d.samp_pre = wb_req.dat[BIT_SAMP_PRE];
			s_d.src = wb_req.dat[POS_SRC +: 2];
			s_d.outsel = wb_req.dat[POS_OUTSEL +: 2];
		end

		// Value window: pointer steps down on each high access until zero
		if (take && (wb_req.adr == OFS_VAL_LOW || wb_req.adr == OFS_VAL_HIGH))
		begin
			lane = wb_req.sel[1:0];
			if (wr && s_q.unlock && lane != 2'h0) // R5
			begin
				s_d.vw.stb = 1'b1;
				s_d.vw.high = (wb_req.adr == OFS_VAL_HIGH);
				s_d.vw.ptr = s_q.ptr;
				s_d.vw.be = lane;
				s_d.vw.dat = wb_req.dat[15:0];
				minutes_seconds_value_low = (wb_req.adr == OFS_VAL_LOW) && (s_q.ptr == PTR_RST) && lane[0];
			end
			if (wb_req.adr == OFS_VAL_HIGH && s_q.ptr != PTR_RST)
				s_d.ptr = s_q.ptr - 2'h1;
		end

		// Timebase source and prescaler
		case (s_q.src)
			SRC_MAINS60, SRC_MAINS50: s_d.tick = rise[2]; // R11
			SRC_INTERNAL_LOW_POWER_OSC: s_d.tick = rise[1]; // R12
			default: s_d.tick = rise[0]; // R12
		endcase
		tps = ticks_per_sec(s_q.src);

		if (s_q.run_en && s_q.tick)
		begin
			inc = 2'h1;
			if (s_q.adj > 9'sd0)
			begin
				inc = 2'h2; // R1
				s_d.adj = s_q.adj - 9'sd1; // R2
			end
			else if (s_q.adj < 9'sd0)
			begin
				inc = 2'h0; // R2
				s_d.adj = s_q.adj + 9'sd1; // R2
			end
			nxt = {1'b0, s_q.cnt} + {15'h0000, inc};
			if (nxt >= {1'b0, tps})
			begin
				nxt = nxt - {1'b0, tps};
				s_d.sec = 1'b1;
				if (s_q.sec15 == TRIM_INTERVAL_S - 4'h1)
				begin
					s_d.sec15 = 4'h0;
					s_d.adj = 9'(signed'(s_q.cal)); // R1 R2
				end
				else
					s_d.sec15 = s_q.sec15 + 4'h1;
			end
			s_d.cnt = nxt[15:0];
		end
		s_d.half = (s_d.cnt >= (tps >> 1)); // R7

		if (minutes_seconds_value_low)
		begin
			s_d.cnt = 16'h0000;
			s_d.half = 1'b0; // R6
			s_d.presc_rst = 1'b1; // R13
		end

		// Power control window clocks
		if (s_q.pwc_en && s_q.tick) // R8
		begin
			s_d.stab_tgl = ~s_q.stab_tgl;
			s_d.samp_tgl = ~s_q.samp_tgl;
			s_d.stab_tick = ~s_q.stab_pre | s_q.stab_tgl; // R9
			s_d.samp_tick = ~s_q.samp_pre | s_q.samp_tgl; // R10
		end

		// Clock output routing
		case (s_q.outsel)
			OUT_PWC: s_d.cko = pwc_signal & s_q.pwc_en; // R14
			OUT_TIMEBASE: s_d.cko = s_q.src[1] ? s_q.level[2] : s_q.level[s_q.src[0]]; // R14
			OUT_SECONDS: s_d.cko = s_q.half; // R14
			default: s_d.cko = alarm_pulse; // R14
		endcase
		s_d.cko = s_d.cko & s_q.oe;
	end

	// ****************************************************************
	// Registers, reset only by power-on reset
	// ****************************************************************
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_q <= '0;
			s_q.cal <= CAL_RST; // R3
			s_q.ptr <= PTR_RST; // R3
			s_q.src <= SRC_RST; // R3
			s_q.outsel <= OUTSEL_RST; // R3
		end
		else
			s_q <= s_d;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign wb_rsp.ack = s_q.ack;
	assign wb_rsp.dat = s_q.rdat;
	assign val_wr = s_q.vw;
	assign value_ptr = s_q.ptr;
	assign clock_run_enable = s_q.run_en;
	assign power_ctl_enable = s_q.pwc_en;
	assign power_ctl_polarity = s_q.pwc_pol;
	assign prescaler_reset = s_q.presc_rst;
	assign timebase_tick = s_q.tick;
	assign seconds_tick = s_q.sec;
	assign stab_window_tick = s_q.stab_tick;
	assign samp_window_tick = s_q.samp_tick;
	assign clk_out = s_q.cko;
	assign clk_out_en = s_q.oe;
endmodule

// ===== verification/rtp_trim_power_monitor.sv
// Checker of bus, strobe and window tick relations of the trim block
`timescale 1ns/1ps
module rtp_trim_power_monitor
	import rtp_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire rtp_pkg::rtp_wb_req_s wb_req,
	input wire rtp_pkg::rtp_wb_rsp_s wb_rsp,
	input wire rtp_pkg::rtp_val_wr_s val_wr,
	input wire logic clock_run_enable,
	input wire logic power_ctl_enable,
	input wire logic prescaler_reset,
	input wire logic stab_window_tick,
	input wire logic samp_window_tick
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	logic tk;
	assign tk = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
	a_ack_next:
	assert property (tk |=> wb_rsp.ack) else $error("ack missing");
	a_ack_pulse:
	assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack held");
	a_hi_zero:
	assert property (wb_rsp.ack |-> wb_rsp.dat[31:16] == 16'h0000) else $error("upper half set");
	a_run_cause:
	assert property ($changed(clock_run_enable) |-> $past(tk && wb_req.we
		&& wb_req.adr == OFS_CAL_CFG && wb_req.sel[1])) else $error("run enable moved");
	a_val_cause:
	assert property (val_wr.stb |-> $past(tk && wb_req.we && wb_req.adr[3]))
		else $error("stray value write");
	a_val_fields:
	assert property (val_wr.stb |-> val_wr.dat == $past(wb_req.dat[15:0])
		&& val_wr.high == $past(wb_req.adr[2])) else $error("value write fields");
	a_presc_cause:
	assert property (prescaler_reset |-> val_wr.stb && !val_wr.high && val_wr.ptr == 2'h0
		&& val_wr.be[0]) else $error("stray prescaler reset");
	a_win_off:
	assert property (!power_ctl_enable && !$past(power_ctl_enable)
		|-> !stab_window_tick && !samp_window_tick) else $error("window tick while off");
	c_wr: cover property (tk && wb_req.we);
	c_val: cover property (val_wr.stb);
	c_stab: cover property (stab_window_tick);
endmodule

// ===== verification/test_rtp_trim_power.sv
// Self-checking bench for the calibration and power control registers
`timescale 1ns/1ps
module test_rtp_trim_power;
	import rtp_pkg::*;
	logic clk, arst_n, pwc_signal, alarm_pulse, run_en, pwc_en, clk_out, oe;
	logic pre, tb_tk, stab_tk, samp_tk, sec_tk;
	logic [2:0] pin;
	logic [15:0] rd_val, t;
	rtp_wb_req_s wb_req;
	rtp_wb_rsp_s wb_rsp;
	rtp_val_wr_s val_wr;
	int bad_count = 0, checks = 0, n_val = 0, n_pre = 0, n_tb = 0, n_stab = 0, n_samp = 0;
	int n_sec = 0;
	logic [15:0] exp_q[$];
	logic [15:0] msk_q[$];
	rtp_trim_power #(.SECONDARY_CRYSTAL_OSC_HZ(8), .INTERNAL_LOW_POWER_OSC_HZ(8)) u_dut (.clk, .arst_n, .wb_req, .wb_rsp,
		.secondary_crystal_osc_pin(pin[0]), .internal_low_power_osc_pin(pin[1]), .mains_pin(pin[2]), .ripple_pending(1'b0),
		.value_rd_data(rd_val), .pwc_signal, .alarm_pulse, .val_wr, .value_ptr(),
		.clock_run_enable(run_en), .power_ctl_enable(pwc_en), .power_ctl_polarity(),
		.prescaler_reset(pre), .timebase_tick(tb_tk), .seconds_tick(sec_tk),
		.stab_window_tick(stab_tk), .samp_window_tick(samp_tk), .clk_out, .clk_out_en(oe));
	// ****************************************************************
	// Tasks and watchers
	// ****************************************************************
	task automatic chk(input logic ok, input string m);
		checks++;
		if (!ok)
		begin
			bad_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s,
		input logic [15:0] d, input logic [15:0] e, input logic [15:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		wb_req <= '{1'b1, 1'b1, w, a, s, {16'h0000, d}};
		@(posedge clk);
		while (wb_rsp.ack !== 1'b1)
			@(posedge clk);
		wb_req <= '0;
		@(posedge clk);
	endtask
	task automatic pulse(input int k, input int n);
		repeat (n)
		begin
			pin[k] <= 1'b1;
			repeat (6) @(posedge clk);
			pin[k] <= 1'b0;
			repeat (6) @(posedge clk);
		end
	endtask
	always @(posedge clk)
		if (wb_rsp.ack === 1'b1 && exp_q.size() > 0)
			chk((wb_rsp.dat[15:0] & msk_q.pop_front()) === exp_q.pop_front(), "read data");
	always @(posedge clk)
	begin
		n_val += (val_wr.stb === 1'b1);
		n_pre += (pre === 1'b1);
		n_tb += (tb_tk === 1'b1);
		n_stab += (stab_tk === 1'b1);
		n_samp += (samp_tk === 1'b1);
		n_sec += (sec_tk === 1'b1);
	end
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		end_of_test();
	end
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		void'($urandom(72));
		arst_n = 1'b0;
		wb_req = '0;
		pin = '0;
		pwc_signal = 1'b0;
		alarm_pulse = 1'b0;
		rd_val = 16'($urandom);
		t = 16'($urandom);
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		bus(0, OFS_CAL_CFG, 4'hF, 0, 16'h0000, 16'hFFFF);
		bus(0, OFS_PWR_CTL, 4'hF, 0, 16'h0000, 16'hFFFF);
		bus(0, 4'h2, 4'hF, 0, 16'h0000, 16'hFFFF);
		bus(1, OFS_CAL_CFG, 4'h2, 16'h8000, 0, 0);
		bus(1, OFS_VAL_LOW, 4'h3, t, 0, 0);
		bus(0, OFS_CAL_CFG, 4'hF, 0, 16'h0000, 16'hFFFF);
		chk(run_en === 1'b0 && n_val == 0 && n_pre == 0, "locked writes");
		bus(1, OFS_CAL_CFG, 4'h2, 16'h2000, 0, 0);
		bus(1, OFS_CAL_CFG, 4'h3, 16'hA000 | t[7:0], 0, 0);
		bus(0, OFS_CAL_CFG, 4'hF, 0, 16'hA000 | t[7:0], 16'hF7FF);
		chk(run_en === 1'b1, "run enable");
		bus(1, OFS_VAL_LOW, 4'h3, t, 0, 0);
		chk(n_val == 1 && n_pre == 1, "value write");
		bus(0, OFS_VAL_LOW, 4'hF, 0, rd_val, 16'hFFFF);
		pulse(0, 3);
		bus(0, OFS_CAL_CFG, 4'hF, 0, 16'h0000, 16'h0800);
		pulse(0, 1);
		bus(0, OFS_CAL_CFG, 4'hF, 0, 16'h0800, 16'h0800);
		bus(1, OFS_VAL_LOW, 4'h1, t, 0, 0);
		bus(0, OFS_CAL_CFG, 4'hF, 0, 16'h0000, 16'h0800);
		for (int i = 0; i < 3; i++)
		begin
			bus(1, OFS_PWR_CTL, 4'h2, i == 0 ? 16'hA000 : i == 1 ? 16'h9000 : 16'h0000, 0, 0);
			n_stab = 0;
			n_samp = 0;
			pulse(0, 8);
			chk(n_stab == (i == 0 ? 4 : i == 1 ? 8 : 0), "stability ticks");
			chk(n_samp == (i == 0 ? 8 : i == 1 ? 4 : 0), "sample ticks");
		end
		for (int c = 0; c < 4; c++)
		begin
			bus(1, OFS_PWR_CTL, 4'h2, 16'(c) << 10, 0, 0);
			bus(1, OFS_VAL_LOW, 4'h1, t, 0, 0);
			n_tb = 0;
			pulse(0, 2);
			pulse(1, 3);
			pulse(2, 4);
			chk(n_tb == (c == 0 ? 2 : c == 1 ? 3 : 4), "timebase source");
		end
		bus(1, OFS_CAL_CFG, 4'h2, 16'hA400, 0, 0);
		for (int c = 0; c < 4; c++)
		begin
			bus(1, OFS_PWR_CTL, 4'h2, (16'(c) << 8) | (c == 3 ? 16'h8000 : 16'h0000), 0, 0);
			{pwc_signal, alarm_pulse, pin[0]} <= 3'($urandom);
			repeat (8) @(posedge clk);
			if (c != 1)
				chk(clk_out === (c == 3 ? pwc_signal : c == 2 ? pin[0] : alarm_pulse)
					&& oe === 1'b1, "output route");
		end
		// Zero trim: sixteen ticks from a cleared count give exactly two seconds
		pin[0] <= 1'b0;
		repeat (6) @(posedge clk);
		bus(1, OFS_CAL_CFG, 4'h1, 0, 0, 0);
		bus(1, OFS_VAL_LOW, 4'h1, t, 0, 0);
		n_sec = 0;
		pulse(0, 16);
		chk(n_sec == 2, "seconds count");
		end_of_test();
	end
endmodule
bind rtp_trim_power rtp_trim_power_monitor u_mon (.clk, .arst_n, .wb_req, .wb_rsp, .val_wr,
	.clock_run_enable, .power_ctl_enable, .prescaler_reset, .stab_window_tick,
	.samp_window_tick);
